// ===== rtl/pviu_ctrl.sv
// interrupt controller top: request latches, arbitration, vectors, bus slave
// assumes the core pulses instr_boundary and follows accept with push and fetch
`timescale 1ns/100ps
module pviu_ctrl
  import pviu_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [5:0]  ext_edge_in,
  input  wire logic [1:0]  counter_pin,
  input  wire logic        sio_selected,
  input  wire logic        sio_rx_done,
  input  wire logic        sio_tx_shift_done,
  input  wire logic        sio_tx_buf_empty,
  input  wire logic [3:0]  timer_underflow,
  input  wire logic        soft_break_instr,
  input  wire logic        instr_boundary,
  input  wire logic [7:0]  core_ps,
  output logic             accept,
  output logic [15:0]      vector_addr,
  output logic [7:0]       stacked_ps,
  output logic [4:0]       accept_src,
  output logic             global_dis,
  output logic             irq
);
  import pviu_pkg::*;

  pviu_edge_if #(.N(NPIN)) eb ();
  pviu_edge_det u_edge (.hclk(hclk), .hresetn(hresetn), .eb(eb));

  logic [NSRC-1:0] req;
  logic [NSRC-1:0] enable;
  logic [NPIN-1:0] edge_rise;
  logic            brk_pend;
  logic            rst_pend;
  logic            ap_valid;
  logic            ap_write;
  logic [7:0]      ap_addr;
  logic [NSRC-1:0] hw_set;
  logic [NSRC-1:0] sw_clr;
  logic [NSRC-1:0] acc_clr;
  logic [NSRC-1:0] ready_req;
  logic            take_mask;
  logic [3:0]      win;
  pviu_kind_t      next_kind;
  logic            wr;

  assign eb.pins   = {ext_edge_in[5:2], counter_pin, ext_edge_in[1:0]};
  assign eb.rising = edge_rise;

  // pick lowest index among candidates
  function automatic logic [3:0] prio_pick(input logic [NSRC-1:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = NSRC - 1; i >= 0; i--)
      if (v[i])
        r = 4'(i);
    return r;
  endfunction : prio_pick

  function automatic logic [15:0] vec_of(input logic [3:0] idx);
    return VEC_FIRST - {11'h000, idx, 1'b0};
  endfunction : vec_of

  // hardware events into request bits
  always_comb
  begin
    hw_set          = '0;
    hw_set[S_EXT0]  = eb.hit[0];
    hw_set[S_EXT1]  = eb.hit[1];
    hw_set[S_CNT0]  = eb.hit[2];
    hw_set[S_CNT1]  = eb.hit[3];
    hw_set[S_EXT2 +: 4] = eb.hit[7:4];
    hw_set[S_RX]    = sio_selected & sio_rx_done;
    hw_set[S_TX]    = sio_selected & (sio_tx_shift_done | sio_tx_buf_empty);
    hw_set[S_TMX]   = timer_underflow[0];
    hw_set[S_TMY]   = timer_underflow[1];
    hw_set[S_TM1]   = timer_underflow[2];
    hw_set[S_TM2]   = timer_underflow[3];
  end

  // arbitration
  assign ready_req = req & enable;
  assign take_mask = instr_boundary & ~rst_pend & ~global_dis & (|ready_req);
  assign win       = prio_pick(ready_req);

  always_comb
  begin
    next_kind = pviu_idle;
    if (instr_boundary)
    begin
      if (rst_pend)
        next_kind = pviu_reset;
      else if (take_mask)
        next_kind = pviu_maskable;
      else if (brk_pend)
        next_kind = pviu_break;
    end
  end

  always_comb
  begin
    acc_clr = '0;
    if (next_kind == pviu_maskable)
      acc_clr[win] = 1'b1;
  end

  // bus address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr  <= 8'h00;
    end
    else if (hready)
    begin
      ap_valid <= hsel & htrans[1];
      ap_write <= hwrite;
      ap_addr  <= haddr[7:0];
    end
  end

  assign wr     = ap_valid & ap_write;
  assign sw_clr = (wr && ap_addr == ADDR_REQ_CLR) ? hwdata[NSRC-1:0] : '0;

  // request latches: set wins over any clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      req <= '0;
    else
      req <= (req & ~sw_clr & ~acc_clr) | hw_set;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      enable <= RST_ENABLE;
    else if (wr && ap_addr == ADDR_ENABLE)
      enable <= hwdata[NSRC-1:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      edge_rise <= RST_EDGE;
    else if (wr && ap_addr == ADDR_EDGE)
      edge_rise <= hwdata[NPIN-1:0];
  end

  // break pending, set wins over acceptance
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      brk_pend <= 1'b0;
    else
      brk_pend <= soft_break_instr | (brk_pend & (next_kind != pviu_break));
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rst_pend <= 1'b1;
    else if (next_kind == pviu_reset)
      rst_pend <= 1'b0;
  end

  // global disable flag
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      global_dis <= RST_IDIS;
    else if (next_kind != pviu_idle)
      global_dis <= 1'b1;
    else if (wr && ap_addr == ADDR_CTRL)
      global_dis <= hwdata[0];
  end

  // acceptance outputs towards the core
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      accept      <= 1'b0;
      vector_addr <= 16'h0000;
      stacked_ps  <= 8'h00;
      accept_src  <= 5'h00;
    end
    else
    begin
      accept <= (next_kind != pviu_idle);
      if (next_kind != pviu_idle)
      begin
        stacked_ps           <= core_ps;
        stacked_ps[PS_I_BIT] <= global_dis;
        stacked_ps[PS_B_BIT] <= (next_kind == pviu_break);
      end
      unique case (next_kind)
        pviu_reset:
        begin
          vector_addr <= VEC_RESET;
          accept_src  <= ID_RESET;
        end
        pviu_maskable:
        begin
          vector_addr <= vec_of(win);
          accept_src  <= {1'b0, win};
        end
        pviu_break:
        begin
          vector_addr <= VEC_BREAK;
          accept_src  <= ID_BREAK;
        end
        pviu_idle:
        begin
          vector_addr <= vector_addr;
          accept_src  <= accept_src;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq <= 1'b0;
    else
      irq <= |ready_req;
  end

  // read data registered from the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (hready && hsel && htrans[1] && !hwrite)
    begin
      unique case (haddr[7:0])
        ADDR_REQ:    hrdata <= {18'h00000, req};
        ADDR_ENABLE: hrdata <= {18'h00000, enable};
        ADDR_EDGE:   hrdata <= {24'h000000, edge_rise};
        ADDR_CTRL:   hrdata <= {31'h00000000, global_dis};
        ADDR_STATE:  hrdata <= {24'h000000, rst_pend, brk_pend, 1'b0, accept_src};
        default:     hrdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  sequence boundary_mask_s;
    instr_boundary && !rst_pend && !global_dis && (|ready_req);
  endsequence
  sequence accept_disable_s;
    accept && global_dis;
  endsequence

  mask_take_a: assert property (@(posedge hclk) disable iff (!hresetn)
    boundary_mask_s |=> accept_disable_s)
    else $error("enabled request not taken");
  masked_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (instr_boundary && global_dis && !brk_pend && !rst_pend) |=> !accept)
    else $error("accept while disabled");
  break_take_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (instr_boundary && brk_pend && !rst_pend && !take_mask)
      |=> accept && vector_addr == VEC_BREAK && stacked_ps[PS_B_BIT])
    else $error("break not taken");
  set_disable_a: assert property (@(posedge hclk) disable iff (!hresetn)
    accept |-> global_dis)
    else $error("disable flag clear after accept");
  req_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    take_mask |=> !req[$past(win)] || $past(hw_set[win]))
    else $error("request not cleared on accept");
  prio_vec_a: assert property (@(posedge hclk) disable iff (!hresetn)
    take_mask |=> vector_addr == VEC_FIRST - {11'h000, $past(win), 1'b0})
    else $error("wrong vector");
  prio_order_a: assert property (@(posedge hclk) disable iff (!hresetn)
    take_mask |-> (ready_req & ((14'h0001 << win) - 14'h0001)) == 14'h0000)
    else $error("lower priority chosen");
  sw_noset_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (hw_set == '0) |=> (req & ~$past(req)) == '0)
    else $error("request set without event");
  timer_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    timer_underflow[0] |=> req[S_TMX])
    else $error("timer request missing");
  rst_first_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (instr_boundary && rst_pend) |=> accept && vector_addr == VEC_RESET)
    else $error("reset vector not first");
  live_b_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (accept && accept_src != ID_BREAK) |-> !stacked_ps[PS_B_BIT])
    else $error("break flag on non-break");
  sw_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (sw_clr != '0) |=> (req & $past(sw_clr) & ~$past(hw_set)) == '0)
    else $error("request survived software clear");
  en_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr && ap_addr == ADDR_ENABLE) |=> enable == $past(hwdata[NSRC-1:0]))
    else $error("enable write lost");
  rx_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (!sio_selected && !req[S_RX]) |=> !req[S_RX])
    else $error("receive request while serial off");
  tx_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (sio_selected && (sio_tx_shift_done || sio_tx_buf_empty)) |=> req[S_TX])
    else $error("transmit request missing");
  dis_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (global_dis && !(wr && ap_addr == ADDR_CTRL)) |=> global_dis)
    else $error("disable flag dropped without write");
  pin_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    eb.hit[0] |=> req[S_EXT0])
    else $error("pin request missing");
  src_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
    accept |-> (accept_src < 5'(NSRC)) || accept_src == ID_RESET || accept_src == ID_BREAK)
    else $error("unknown source accepted");
  ps_copy_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (next_kind != pviu_idle) |=> accept && stacked_ps[PS_I_BIT] == $past(global_dis)
      && (stacked_ps & 8'heb) == $past(core_ps & 8'heb))
    else $error("stacked status not a copy");
  irq_high_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (|ready_req) |=> irq)
    else $error("irq low with enabled request");
  irq_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !(|ready_req) |=> !irq)
    else $error("irq high without enabled request");
  brk_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (brk_pend && !(instr_boundary && !rst_pend && !take_mask)) |=> brk_pend)
    else $error("break lost before boundary");
endmodule : pviu_ctrl

// ===== rtl/pviu_edge_det.sv
// synchronises the external pins and flags the selected edge of each
// assumes pins are asynchronous to hclk
`timescale 1ns/100ps
module pviu_edge_det
  import pviu_pkg::*;
(
  input  wire logic  hclk,
  input  wire logic  hresetn,
  pviu_edge_if.det   eb
);
  logic [NPIN-1:0] meta;
  logic [NPIN-1:0] sync;
  logic [NPIN-1:0] prev;
  logic [NPIN-1:0] hit;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta <= '0;
      sync <= '0;
      prev <= '0;
    end
    else
    begin
      meta <= eb.pins;
      sync <= meta;
      prev <= sync;
    end
  end

  // one-cycle event on the selected edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hit <= '0;
    else
      hit <= (eb.rising & sync & ~prev) | (~eb.rising & ~sync & prev);
  end

  assign eb.hit = hit;
endmodule : pviu_edge_det

// ===== rtl/pviu_edge_if.sv
// bundle between the pin edge detector and the controller
// assumes both ends share hclk
`timescale 1ns/100ps
interface pviu_edge_if #(parameter int N = 8);
  logic [N-1:0] pins;
  logic [N-1:0] rising;
  logic [N-1:0] hit;
  modport det (input pins, input rising, output hit);
  modport ctl (output pins, output rising, input hit);
endinterface : pviu_edge_if

// ===== rtl/pviu_pkg.sv
// prioritized vectored interrupt unit: constants, register map, source indices
// assumes a single 125 MHz clock shared with the processor core
// What this block does
// - fifteen sources: eight pins, six internal, break
// - maskable taken when requested, enabled, disable flag clear
// - software writes set and clear enable bits
// - software clears request bits, never sets them
// - break ignores enables and the disable flag
// - acceptance makes core push program counter, status
// - acceptance sets the global disable flag
// - acceptance clears request bit, loads source vector
// - fixed priority, reset first, break last
// - two byte vectors stepping down from top
// - pin sources set request on selected edge
// - serial receive request needs serial selected
// - serial transmit request on shift done or empty
// - each timer underflow sets its request bit
// - reset acts as highest non-maskable interrupt
// - disable flag is one after reset
// - stacked status carries break flag for break
package pviu_pkg;
  localparam int          NSRC         = 14;
  localparam int          NPIN         = 8;
  localparam logic [7:0]  ADDR_REQ     = 8'h00;
  localparam logic [7:0]  ADDR_REQ_CLR = 8'h04;
  localparam logic [7:0]  ADDR_ENABLE  = 8'h08;
  localparam logic [7:0]  ADDR_EDGE    = 8'h0c;
  localparam logic [7:0]  ADDR_CTRL    = 8'h10;
  localparam logic [7:0]  ADDR_STATE   = 8'h14;
  localparam logic [13:0] RST_ENABLE   = 14'h0000;
  localparam logic [7:0]  RST_EDGE     = 8'h00;
  localparam logic        RST_IDIS     = 1'b1;
  localparam int          PS_I_BIT     = 2;
  localparam int          PS_B_BIT     = 4;
  localparam logic [15:0] VEC_RESET    = 16'hfffc;
  localparam logic [15:0] VEC_FIRST    = 16'hfffa;
  localparam logic [15:0] VEC_BREAK    = 16'hffdc;
  localparam logic [4:0]  ID_RESET     = 5'h1f;
  localparam logic [4:0]  ID_BREAK     = 5'h1e;
  // source bit positions, index order is priority order
  localparam int S_EXT0 = 0;
  localparam int S_EXT1 = 1;
  localparam int S_RX   = 2;
  localparam int S_TX   = 3;
  localparam int S_TMX  = 4;
  localparam int S_TMY  = 5;
  localparam int S_TM1  = 6;
  localparam int S_TM2  = 7;
  localparam int S_CNT0 = 8;
  localparam int S_CNT1 = 9;
  localparam int S_EXT2 = 10;
  typedef enum logic [1:0] {pviu_idle, pviu_maskable, pviu_break, pviu_reset} pviu_kind_t;
endpackage : pviu_pkg

// ===== testbench/pviu_core_model.sv
// core stand-in: ends an instruction every few cycles, pauses after each acceptance
// assumes accept is a one-cycle pulse from the controller on hclk
`timescale 1ns/100ps
module pviu_core_model
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       accept,
  input  wire logic       global_dis,
  output logic            instr_boundary,
  output logic [7:0]      core_ps
);
  logic [2:0] hold;
  // live status keeps the break flag at 0; disable flag follows the controller
  assign core_ps = {3'b101, 1'b0, 1'b1, global_dis, 2'b01};
  // five quiet cycles: push pc high, pc low, status, then vector fetch
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hold           <= 3'd0;
      instr_boundary <= 1'b0;
    end
    else if (accept)
    begin
      hold <= 3'd4;
    end
    else if (instr_boundary)
    begin
      instr_boundary <= 1'b0;
      hold           <= 3'd1;
    end
    else if (hold != 3'd0)
    begin
      hold <= hold - 3'd1;
    end
    else
    begin
      instr_boundary <= 1'b1;
    end
  end
endmodule : pviu_core_model

// ===== testbench/pviu_tb_top.sv
// bench for the interrupt unit: bus tasks, event drivers, one task per scenario
// assumes the core stand-in model answers on the same clock
`timescale 1ns/100ps
module pviu_tb_top;
  import pviu_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, counter_pin;
  logic [2:0]  hsize;
  logic [5:0]  ext_edge_in;
  logic [3:0]  timer_underflow;
  logic        sio_selected, sio_rx_done, sio_tx_shift_done, sio_tx_buf_empty;
  logic        soft_break_instr, instr_boundary, accept, global_dis, irq;
  logic [7:0]  core_ps, stacked_ps, a_ps;
  logic [15:0] vector_addr, a_vec;
  logic [4:0]  accept_src, a_src;
  int          err_count, checked, n_acc;

  always #4 hclk = ~hclk;
  assign hready = hreadyout;

  pviu_ctrl dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .ext_edge_in, .counter_pin, .sio_selected,
    .sio_rx_done, .sio_tx_shift_done, .sio_tx_buf_empty, .timer_underflow,
    .soft_break_instr, .instr_boundary, .core_ps, .accept, .vector_addr, .stacked_ps,
    .accept_src, .global_dis, .irq);
  pviu_core_model core_u (.hclk, .hresetn, .accept, .global_dis, .instr_boundary, .core_ps);

  // record each acceptance where outputs are settled
  always @(negedge hclk)
    if (accept === 1'b1)
    begin
      n_acc++;
      a_vec = vector_addr;
      a_src = accept_src;
      a_ps  = stacked_ps;
    end

  task stop_test;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task rdy;
    int k;
    @(posedge hclk);
    for (k = 0; k < 50 && hreadyout !== 1'b1; k++)
      @(posedge hclk);
    if (k >= 50)
    begin
      chk(0, 1, "bus hang");
      stop_test;
    end
  endtask : rdy

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= w;
    rdy;
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rdy;
    rd = hrdata;
    chk(hresp, 0, "response not okay");
  endtask : bus

  task wait_acc(input int n0);
    int k;
    for (k = 0; k < 100 && n_acc == n0; k++)
      @(posedge hclk);
    if (n_acc == n0)
    begin
      chk(0, 1, "no accept");
      stop_test;
    end
  endtask : wait_acc

  task trig(input int i);
    @(posedge hclk);
    case (i)
      0, 1:       ext_edge_in[i] <= ~ext_edge_in[i];
      2:          sio_rx_done <= 1'b1;
      3:          sio_tx_buf_empty <= 1'b1;
      4, 5, 6, 7: timer_underflow[i-4] <= 1'b1;
      8, 9:       counter_pin[i-8] <= ~counter_pin[i-8];
      99:         ;
      default:    ext_edge_in[i-8] <= ~ext_edge_in[i-8];
    endcase
    @(posedge hclk);
    {sio_rx_done, sio_tx_buf_empty, sio_tx_shift_done, timer_underflow} <= '0;
    repeat (6) @(posedge hclk);
  endtask : trig

  task sc_reset;
    wait_acc(0);
    chk(a_vec, VEC_RESET, "reset vector");
    chk(a_src, ID_RESET, "reset source");
    chk(global_dis, 1, "disable after reset");
    bus(0, ADDR_EDGE, 0);
    chk(rd, RST_EDGE, "edge reset value");
    bus(0, ADDR_STATE, 0);
    chk(rd, {27'h0, ID_RESET}, "state after reset");
  endtask : sc_reset

  task sc_regs;
    int n;
    n = n_acc;
    bus(1, ADDR_ENABLE, 32'h3fff);
    bus(0, ADDR_ENABLE, 0);
    chk(rd, 32'h3fff, "enable set");
    bus(1, ADDR_REQ, 32'h3fff);
    bus(0, ADDR_REQ, 0);
    chk(rd, 0, "request set by write");
    bus(0, 8'h20, 0);
    chk(rd, 0, "unmapped read");
    bus(1, ADDR_ENABLE, 32'h8);
    @(posedge hclk);
    sio_tx_shift_done <= 1'b1;
    trig(99);
    bus(0, ADDR_REQ, 0);
    chk(rd, 32'h8, "tx request latched");
    chk(irq, 1, "irq raised");
    bus(1, ADDR_ENABLE, 0);
    repeat (2) @(posedge hclk);
    chk(irq, 0, "irq masked");
    bus(1, ADDR_ENABLE, 32'h8);
    bus(1, ADDR_REQ_CLR, 32'h8);
    repeat (2) @(posedge hclk);
    chk(irq, 0, "irq cleared");
    chk(n_acc, n, "taken while disabled");
    sio_selected <= 1'b0;
    trig(2);
    trig(3);
    bus(0, ADDR_REQ, 0);
    chk(rd, 0, "serial request while deselected");
    sio_selected <= 1'b1;
  endtask : sc_regs

  task sc_each;
    int i, n;
    bus(1, ADDR_EDGE, 32'hff);
    for (i = 0; i < NSRC; i++)
    begin
      bus(1, ADDR_ENABLE, 32'h1 << i);
      bus(1, ADDR_REQ_CLR, 32'h3fff);
      trig(i);
      bus(0, ADDR_REQ, 0);
      chk(rd, 32'h1 << i, "request latched");
      n = n_acc;
      bus(1, ADDR_CTRL, 0);
      wait_acc(n);
      chk(a_src, i, "source");
      chk(a_vec, VEC_FIRST - 2 * i, "vector");
      chk(a_ps, 8'ha9, "stacked status");
      chk(global_dis, 1, "disable set");
      bus(0, ADDR_REQ, 0);
      chk(rd, 0, "request cleared");
    end
  endtask : sc_each

  task sc_fall;
    bus(1, ADDR_ENABLE, 0);
    bus(1, ADDR_EDGE, 0);
    bus(1, ADDR_REQ_CLR, 32'h3fff);
    trig(0);
    bus(0, ADDR_REQ, 0);
    chk(rd, 1, "falling edge");
    bus(1, ADDR_REQ_CLR, 32'h1);
    trig(0);
    bus(0, ADDR_REQ, 0);
    chk(rd, 0, "rising ignored");
  endtask : sc_fall

  task sc_prio;
    int n;
    bus(1, ADDR_ENABLE, 32'h90);
    @(posedge hclk);
    timer_underflow <= 4'b1001;
    trig(99);
    n = n_acc;
    bus(1, ADDR_CTRL, 0);
    wait_acc(n);
    chk(a_src, S_TMX, "first of two");
    n = n_acc;
    bus(1, ADDR_CTRL, 0);
    wait_acc(n);
    chk(a_src, S_TM2, "second of two");
  endtask : sc_prio

  task sc_break;
    int n;
    n = n_acc;
    @(posedge hclk);
    soft_break_instr <= 1'b1;
    @(posedge hclk);
    soft_break_instr <= 1'b0;
    wait_acc(n);
    chk(a_src, ID_BREAK, "break while disabled");
    chk(a_vec, VEC_BREAK, "break vector");
    chk(a_ps, 8'hbd, "break flag stacked");
  endtask : sc_break

  initial
  begin
    hclk              = 0;
    hresetn           = 0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize             = 3'b010;
    ext_edge_in       = 0;
    counter_pin       = 0;
    sio_selected      = 1;
    {sio_rx_done, sio_tx_shift_done, sio_tx_buf_empty} = '0;
    timer_underflow   = 0;
    soft_break_instr  = 0;
    err_count         = 0;
    checked           = 0;
    n_acc             = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    sc_reset;
    sc_regs;
    sc_each;
    sc_fall;
    sc_prio;
    sc_break;
    stop_test;
  end
endmodule : pviu_tb_top
